// ---- src/urd_mgmt_if.sv ----
// Signals between the mode control and its management target
`timescale 1ns/1ps
`default_nettype none
interface urd_mgmt_if;
   logic enable;
   logic scl;
   logic sda_in;
   logic sda_oe;
   logic wr_stb;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   modport ctrl (output enable, output scl, output sda_in, output rd_data,
      input sda_oe, input wr_stb, input wr_data);
   modport tgt (input enable, input scl, input sda_in, input rd_data,
      output sda_oe, output wr_stb, output wr_data);
endinterface
`default_nettype wire

// ---- src/urd_mgmt_target.sv ----
// Two-wire management target with one read/write configuration byte
`timescale 1ns/1ps
`default_nettype none
module urd_mgmt_target
   import urd_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   urd_mgmt_if.tgt bus
);
   urd_i2c_t st_r, st_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic oe_r, oe_nxt;
   logic rnw_r, rnw_nxt;
   logic stb_r, stb_nxt;
   logic scl_d_r, sda_d_r;
   logic rise, fall, start, stop;

   assign rise = bus.scl & ~scl_d_r;
   assign fall = ~bus.scl & scl_d_r;
   assign start = bus.scl & scl_d_r & sda_d_r & ~bus.sda_in;
   assign stop = bus.scl & scl_d_r & ~sda_d_r & bus.sda_in;
   assign bus.sda_oe = oe_r;
   assign bus.wr_stb = stb_r;
   assign bus.wr_data = sh_r;

   always_comb
   begin
      st_nxt = st_r;
      sh_nxt = sh_r;
      cnt_nxt = cnt_r;
      oe_nxt = oe_r;
      rnw_nxt = rnw_r;
      stb_nxt = 1'b0;
      if (!bus.enable || stop)
      begin
         st_nxt = URD_I2C_IDLE;
         oe_nxt = 1'b0;
      end
      else if (start)
      begin
         st_nxt = URD_I2C_ADDR;
         cnt_nxt = 4'h0;
         oe_nxt = 1'b0;
      end
      else
      begin
         case (st_r)
            URD_I2C_ADDR, URD_I2C_WR:
            begin
               if (rise && cnt_r < 4'(I2C_BITS))
               begin
                  sh_nxt = {sh_r[6:0], bus.sda_in};
                  cnt_nxt = cnt_r + 4'h1;
               end
               else if (fall && cnt_r == 4'(I2C_BITS))
               begin
                  if (st_r == URD_I2C_WR)
                  begin
                     stb_nxt = 1'b1;
                     oe_nxt = 1'b1;
                     st_nxt = URD_I2C_ACK_W;
                  end
                  else if (sh_r[7:1] == MGMT_ADDR)
                  begin
                     rnw_nxt = sh_r[0];
                     oe_nxt = 1'b1;
                     st_nxt = URD_I2C_ACK_A;
                  end
                  else
                     st_nxt = URD_I2C_IDLE;
               end
            end
            URD_I2C_ACK_A, URD_I2C_ACK_W:
            begin
               if (fall)
               begin
                  cnt_nxt = 4'h0;
                  if (rnw_r)
                  begin
                     sh_nxt = {bus.rd_data[6:0], 1'b0};
                     oe_nxt = ~bus.rd_data[7];
                     cnt_nxt = 4'h1;
                     st_nxt = URD_I2C_RD;
                  end
                  else
                  begin
                     oe_nxt = 1'b0;
                     st_nxt = URD_I2C_WR;
                  end
               end
            end
            URD_I2C_RD:
            begin
               if (fall)
               begin
                  if (cnt_r == 4'(I2C_BITS))
                  begin
                     oe_nxt = 1'b0;
                     st_nxt = URD_I2C_ACK_R;
                  end
                  else
                  begin
                     oe_nxt = ~sh_r[7];
                     sh_nxt = {sh_r[6:0], 1'b0};
                     cnt_nxt = cnt_r + 4'h1;
                  end
               end
            end
            URD_I2C_ACK_R:
            begin
               if (rise)
                  st_nxt = bus.sda_in ? URD_I2C_IDLE : URD_I2C_ACK_A;
            end
            default:
               st_nxt = URD_I2C_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         st_r <= URD_I2C_IDLE;
         sh_r <= 8'h00;
         cnt_r <= 4'h0;
         oe_r <= 1'b0;
         rnw_r <= 1'b0;
         stb_r <= 1'b0;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
         sh_r <= sh_nxt;
         cnt_r <= cnt_nxt;
         oe_r <= oe_nxt;
         rnw_r <= rnw_nxt;
         stb_r <= stb_nxt;
         scl_d_r <= bus.scl;
         sda_d_r <= bus.sda_in;
      end
   end
endmodule
`default_nettype wire

// ---- src/urd_mode_ctrl.sv ----
// Strap capture, mode selection and high-speed flag of the redriver
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Boost strap is taken once after power-up; later pin changes are ignored.
// - An open boost strap selects boost level 3.
// - Strap sets edge and DC boost together; management sets them apart.
// - Charging port controller is on while its enable input is low.
// - Strap mode: sensitivity pin read at reset as high, open or low.
// - After reset in strap mode the sensitivity pin drives the HS flag.
// - Flag sets on fixture seen from disconnect, then test packet; in management mode it stays low.
// - Flag sets on squelch after bus reset and one 18-128 us J/K pair; in management mode it stays low.
// - In management mode the target answers at 7-bit address 0x2C.
// - Reset/enable input low holds reset and shutdown; high runs normally.
// - Management mode only if both management lines are high at power-up.
module urd_mode_ctrl
   import urd_pkg::*;
#(
   parameter int CHIRP_MIN = CHIRP_MIN_CYC,
   parameter int CHIRP_MAX = CHIRP_MAX_CYC
)
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_reset_enable_n,
   input wire logic i_charge_port_enable_n,
   input wire logic [1:0] i_boost_strap,
   input wire logic i_boost_strap_open,
   input wire logic i_sens_pin_in,
   input wire logic i_sens_pin_open,
   input wire logic i_mgmt_clock_in,
   input wire logic i_mgmt_data_in,
   input wire logic i_line_disconnected,
   input wire logic i_fixture_detect,
   input wire logic i_test_packet,
   input wire logic i_bus_reset,
   input wire logic i_chirp_j,
   input wire logic i_chirp_k,
   input wire logic i_squelch,
   output logic o_active,
   output logic o_charge_port_en,
   output logic o_mgmt_mode,
   output logic [1:0] o_edge_boost,
   output logic [1:0] o_dc_boost,
   output logic [1:0] o_rx_sensitivity,
   output logic o_sens_pin_out,
   output logic o_sens_pin_oe,
   output logic o_high_speed_active_flag,
   output logic o_mgmt_data_out,
   output logic o_mgmt_data_oe
);
   generate
      if (CHIRP_MIN < 1 || CHIRP_MIN > CHIRP_MAX ||
          CHIRP_MAX >= (1 << CHIRP_CNT_W) - 1)
      begin : g_bad_chirp
         $error("Chirp window does not fit the counter");
      end
   endgenerate

   urd_mgmt_if mif();

   logic taken_r, taken_nxt;
   logic mgmt_r, mgmt_nxt;
   logic [1:0] strap_r, strap_nxt;
   urd_sens_t sens_r, sens_nxt;
   logic active_r, active_nxt;
   logic cdp_r, cdp_nxt;
   logic [7:0] cfg_r, cfg_nxt;
   logic [1:0] edge_r, edge_nxt;
   logic [1:0] dc_r, dc_nxt;
   logic sens_oe_r, sens_oe_nxt;
   urd_hs_t hs_r, hs_nxt;
   logic [CHIRP_CNT_W-1:0] cnt_r, cnt_nxt;
   logic flag_r, flag_nxt;
   logic data_oe_r;
   logic in_window;

   assign mif.enable = mgmt_r & active_r;
   assign mif.scl = i_mgmt_clock_in;
   assign mif.sda_in = i_mgmt_data_in;
   assign mif.rd_data = cfg_r;

   urd_mgmt_target u_target
   (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .bus(mif.tgt)
   );

   // Configuration capture and mode outputs
   always_comb
   begin
      taken_nxt = 1'b1;
      mgmt_nxt = mgmt_r;
      strap_nxt = strap_r;
      sens_nxt = sens_r;
      cfg_nxt = cfg_r;
      if (!taken_r)
      begin
         mgmt_nxt = i_mgmt_clock_in & i_mgmt_data_in;
         strap_nxt = i_boost_strap_open ? BOOST_OPEN_LEVEL :
            i_boost_strap;
      end
      if (!taken_r || !i_reset_enable_n)
      begin
         if (i_sens_pin_open)
            sens_nxt = URD_SENS_MED;
         else if (i_sens_pin_in)
            sens_nxt = URD_SENS_HIGH;
         else
            sens_nxt = URD_SENS_LOW;
      end
      if (mif.wr_stb)
         cfg_nxt = mif.wr_data;
      active_nxt = taken_r & i_reset_enable_n;
      cdp_nxt = active_nxt & ~i_charge_port_enable_n;
      if (mgmt_r)
      begin
         edge_nxt = cfg_r[BOOST_EDGE_LSB +: 2];
         dc_nxt = cfg_r[BOOST_DC_LSB +: 2];
      end
      else
      begin
         edge_nxt = strap_r;
         dc_nxt = strap_r;
      end
      sens_oe_nxt = active_nxt & ~mgmt_r;
   end

   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         taken_r <= 1'b0;
         mgmt_r <= 1'b0;
         strap_r <= BOOST_OPEN_LEVEL;
         sens_r <= URD_SENS_MED;
         active_r <= 1'b0;
         cdp_r <= 1'b0;
         cfg_r <= BOOST_CFG_RESET;
         edge_r <= BOOST_OPEN_LEVEL;
         dc_r <= BOOST_OPEN_LEVEL;
         sens_oe_r <= 1'b0;
      end
      else
      begin
         taken_r <= taken_nxt;
         mgmt_r <= mgmt_nxt;
         strap_r <= strap_nxt;
         sens_r <= sens_nxt;
         active_r <= active_nxt;
         cdp_r <= cdp_nxt;
         cfg_r <= cfg_nxt;
         edge_r <= edge_nxt;
         dc_r <= dc_nxt;
         sens_oe_r <= sens_oe_nxt;
      end
   end

   // High-speed detection
   assign in_window = cnt_r >= CHIRP_CNT_W'(CHIRP_MIN) &&
      cnt_r <= CHIRP_CNT_W'(CHIRP_MAX);

   always_comb
   begin
      hs_nxt = hs_r;
      cnt_nxt = cnt_r;
      if (!active_nxt || mgmt_r)
         hs_nxt = URD_HS_IDLE;
      else
      begin
         case (hs_r)
            URD_HS_IDLE:
            begin
               if (i_bus_reset)
                  hs_nxt = URD_HS_BUS_RST;
               else if (i_line_disconnected && i_fixture_detect)
                  hs_nxt = URD_HS_FIXTURE;
            end
            URD_HS_FIXTURE:
            begin
               if (i_test_packet)
                  hs_nxt = URD_HS_ACTIVE;
               else if (!i_fixture_detect)
                  hs_nxt = URD_HS_IDLE;
            end
            URD_HS_BUS_RST:
            begin
               cnt_nxt = '0;
               if (i_chirp_j)
               begin
                  cnt_nxt = CHIRP_CNT_W'(1);
                  hs_nxt = URD_HS_CHIRP_J;
               end
            end
            URD_HS_CHIRP_J, URD_HS_CHIRP_K:
            begin
               if ((hs_r == URD_HS_CHIRP_J) ? i_chirp_j : i_chirp_k)
               begin
                  if (cnt_r <= CHIRP_CNT_W'(CHIRP_MAX))
                     cnt_nxt = cnt_r + 1'b1;
               end
               else if (!in_window)
                  hs_nxt = URD_HS_IDLE;
               else if (hs_r == URD_HS_CHIRP_J && i_chirp_k)
               begin
                  cnt_nxt = CHIRP_CNT_W'(1);
                  hs_nxt = URD_HS_CHIRP_K;
               end
               else if (hs_r == URD_HS_CHIRP_K)
                  hs_nxt = URD_HS_SQ_WAIT;
               else
                  hs_nxt = URD_HS_IDLE;
            end
            URD_HS_SQ_WAIT:
            begin
               if (i_chirp_j || i_chirp_k || i_line_disconnected)
                  hs_nxt = URD_HS_IDLE;
               else if (i_squelch)
                  hs_nxt = URD_HS_ACTIVE;
            end
            URD_HS_ACTIVE:
            begin
               if (i_bus_reset)
                  hs_nxt = URD_HS_BUS_RST;
               else if (i_line_disconnected)
                  hs_nxt = URD_HS_IDLE;
            end
            default:
               hs_nxt = URD_HS_IDLE;
         endcase
      end
      flag_nxt = (hs_nxt == URD_HS_ACTIVE);
   end

   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         hs_r <= URD_HS_IDLE;
         cnt_r <= '0;
         flag_r <= 1'b0;
         data_oe_r <= 1'b0;
      end
      else
      begin
         hs_r <= hs_nxt;
         cnt_r <= cnt_nxt;
         flag_r <= flag_nxt;
         data_oe_r <= mif.sda_oe;
      end
   end

   assign o_active = active_r;
   assign o_charge_port_en = cdp_r;
   assign o_mgmt_mode = mgmt_r;
   assign o_edge_boost = edge_r;
   assign o_dc_boost = dc_r;
   assign o_rx_sensitivity = sens_r;
   assign o_sens_pin_out = flag_r;
   assign o_sens_pin_oe = sens_oe_r;
   assign o_high_speed_active_flag = flag_r;
   assign o_mgmt_data_out = 1'b0;
   assign o_mgmt_data_oe = data_oe_r;
endmodule
`default_nettype wire

// ---- src/urd_pkg.sv ----
// Shared constants and types for the redriver strap and mode control
package urd_pkg;
   localparam int CLK_MHZ = 250;
   localparam logic [6:0] MGMT_ADDR = 7'h2C;
   localparam logic [1:0] BOOST_OPEN_LEVEL = 2'h3;
   localparam logic [7:0] BOOST_CFG_RESET = 8'h0F;
   localparam int BOOST_EDGE_LSB = 0;
   localparam int BOOST_DC_LSB = 2;
   localparam int CHIRP_MIN_US = 18;
   localparam int CHIRP_MAX_US = 128;
   localparam int CHIRP_MIN_CYC = CHIRP_MIN_US * CLK_MHZ;
   localparam int CHIRP_MAX_CYC = CHIRP_MAX_US * CLK_MHZ;
   localparam int CHIRP_CNT_W = 16;
   localparam int I2C_BITS = 8;

   typedef enum logic [1:0]
   {
      URD_SENS_LOW = 2'b00,
      URD_SENS_MED = 2'b01,
      URD_SENS_HIGH = 2'b10
   } urd_sens_t;

   typedef enum logic [2:0]
   {
      URD_HS_IDLE = 3'b000,
      URD_HS_BUS_RST = 3'b001,
      URD_HS_CHIRP_J = 3'b010,
      URD_HS_CHIRP_K = 3'b011,
      URD_HS_SQ_WAIT = 3'b100,
      URD_HS_FIXTURE = 3'b101,
      URD_HS_ACTIVE = 3'b110
   } urd_hs_t;

   typedef enum logic [2:0]
   {
      URD_I2C_IDLE = 3'b000,
      URD_I2C_ADDR = 3'b001,
      URD_I2C_ACK_A = 3'b010,
      URD_I2C_WR = 3'b011,
      URD_I2C_ACK_W = 3'b100,
      URD_I2C_RD = 3'b101,
      URD_I2C_ACK_R = 3'b110
   } urd_i2c_t;
endpackage

// ---- testbench/urd_mode_ctrl_monitor.sv ----
// Port-level assertions for the redriver mode control
`timescale 1ns/1ps
`default_nettype none
module urd_mode_ctrl_monitor
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_reset_enable_n,
   input wire logic i_charge_port_enable_n,
   input wire logic i_sens_pin_open,
   input wire logic i_squelch,
   input wire logic i_test_packet,
   input wire logic o_active,
   input wire logic o_charge_port_en,
   input wire logic o_mgmt_mode,
   input wire logic [1:0] o_edge_boost,
   input wire logic [1:0] o_dc_boost,
   input wire logic [1:0] o_rx_sensitivity,
   input wire logic o_sens_pin_out,
   input wire logic o_sens_pin_oe,
   input wire logic o_high_speed_active_flag,
   input wire logic o_mgmt_data_oe
);
   logic [1:0] age_r;
   logic [1:0] age_nxt;
   logic live;
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_reset);
   // Settled once three edges have passed since power-up
   always_comb
   begin
      age_nxt = (age_r == 2'h3) ? age_r : age_r + 2'h1;
   end
   always_ff @(posedge i_core_clk or posedge i_reset)
   begin
      if (i_reset)
         age_r <= 2'h0;
      else
         age_r <= age_nxt;
   end
   assign live = (age_r == 2'h3);
   property p_charge;
      live |-> o_charge_port_en ==
         $past(!i_charge_port_enable_n && i_reset_enable_n);
   endproperty
   a_charge: assert property (p_charge)
      else $error("charge port enable wrong");
   property p_shutdown;
      live && !i_reset_enable_n |=>
         !o_active && !o_high_speed_active_flag && !o_sens_pin_oe;
   endproperty
   a_shutdown: assert property (p_shutdown)
      else $error("shutdown not honoured");
   property p_boost;
      live && !o_mgmt_mode |-> $stable(o_edge_boost) &&
         o_edge_boost == o_dc_boost;
   endproperty
   a_boost: assert property (p_boost)
      else $error("strap boost moved or split");
   property p_flag_pin;
      live && !o_mgmt_mode |-> o_sens_pin_oe == o_active &&
         o_sens_pin_out == o_high_speed_active_flag;
   endproperty
   a_flag_pin: assert property (p_flag_pin)
      else $error("shared pin not showing flag");
   property p_flag_cause;
      live && $rose(o_high_speed_active_flag) |->
         $past(i_squelch || i_test_packet);
   endproperty
   a_flag_cause: assert property (p_flag_cause)
      else $error("flag rose without cause");
   property p_mode_fixed;
      live |-> $stable(o_mgmt_mode);
   endproperty
   a_mode_fixed: assert property (p_mode_fixed)
      else $error("mode changed after power-up");
   property p_sens_open;
      live && !i_reset_enable_n && i_sens_pin_open && !o_mgmt_mode |=>
         o_rx_sensitivity == 2'h1;
   endproperty
   a_sens_open: assert property (p_sens_open)
      else $error("open pin not medium");
   property p_mgmt_pins;
      (o_mgmt_mode |-> !o_sens_pin_oe && !o_high_speed_active_flag) and
         (!o_mgmt_mode |-> !o_mgmt_data_oe);
   endproperty
   a_mgmt_pins: assert property (p_mgmt_pins)
      else $error("pin driven in wrong mode");
endmodule
bind urd_mode_ctrl urd_mode_ctrl_monitor urd_mode_ctrl_monitor_inst
(
   .i_core_clk(i_core_clk),
   .i_reset(i_reset),
   .i_reset_enable_n(i_reset_enable_n),
   .i_charge_port_enable_n(i_charge_port_enable_n),
   .i_sens_pin_open(i_sens_pin_open),
   .i_squelch(i_squelch),
   .i_test_packet(i_test_packet),
   .o_active(o_active),
   .o_charge_port_en(o_charge_port_en),
   .o_mgmt_mode(o_mgmt_mode),
   .o_edge_boost(o_edge_boost),
   .o_dc_boost(o_dc_boost),
   .o_rx_sensitivity(o_rx_sensitivity),
   .o_sens_pin_out(o_sens_pin_out),
   .o_sens_pin_oe(o_sens_pin_oe),
   .o_high_speed_active_flag(o_high_speed_active_flag),
   .o_mgmt_data_oe(o_mgmt_data_oe)
);
`default_nettype wire

// ---- testbench/urd_mode_ctrl_tb.sv ----
// Self-checking bench for the redriver strap and mode control
`timescale 1ns/1ps
`default_nettype none
module urd_mode_ctrl_tb;
   import urd_pkg::*;
   localparam int CMIN = 5;
   localparam int CMAX = 40;
   localparam logic [7:0] MW = 8'h09;
   logic i_core_clk, i_reset, i_reset_enable_n, i_charge_port_enable_n;
   logic [1:0] i_boost_strap;
   logic i_boost_strap_open, i_sens_pin_in, i_sens_pin_open;
   logic i_mgmt_clock_in, i_mgmt_data_in, i_line_disconnected;
   logic i_fixture_detect, i_test_packet;
   wire logic i_bus_reset, i_chirp_j, i_chirp_k, i_squelch;
   logic o_active, o_charge_port_en, o_mgmt_mode, o_sens_pin_out;
   logic o_sens_pin_oe, o_high_speed_active_flag, o_mgmt_data_out;
   logic o_mgmt_data_oe;
   logic [1:0] o_edge_boost, o_dc_boost, o_rx_sensitivity;
   int n_errors;
   int checked;
   logic [1:0] st;
   logic [2:0] r;
   logic [1:0] ack;

   urd_mode_ctrl #(.CHIRP_MIN(CMIN), .CHIRP_MAX(CMAX)) urd_mode_ctrl_inst
   (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_reset_enable_n(i_reset_enable_n),
      .i_charge_port_enable_n(i_charge_port_enable_n),
      .i_boost_strap(i_boost_strap),
      .i_boost_strap_open(i_boost_strap_open),
      .i_sens_pin_in(i_sens_pin_in),
      .i_sens_pin_open(i_sens_pin_open),
      .i_mgmt_clock_in(i_mgmt_clock_in),
      .i_mgmt_data_in(i_mgmt_data_in),
      .i_line_disconnected(i_line_disconnected),
      .i_fixture_detect(i_fixture_detect),
      .i_test_packet(i_test_packet),
      .i_bus_reset(i_bus_reset),
      .i_chirp_j(i_chirp_j),
      .i_chirp_k(i_chirp_k),
      .i_squelch(i_squelch),
      .o_active(o_active),
      .o_charge_port_en(o_charge_port_en),
      .o_mgmt_mode(o_mgmt_mode),
      .o_edge_boost(o_edge_boost),
      .o_dc_boost(o_dc_boost),
      .o_rx_sensitivity(o_rx_sensitivity),
      .o_sens_pin_out(o_sens_pin_out),
      .o_sens_pin_oe(o_sens_pin_oe),
      .o_high_speed_active_flag(o_high_speed_active_flag),
      .o_mgmt_data_out(o_mgmt_data_out),
      .o_mgmt_data_oe(o_mgmt_data_oe)
   );
   urd_usb_partner urd_usb_partner_inst (.i_clk(i_core_clk),
      .o_bus_reset(i_bus_reset), .o_chirp_j(i_chirp_j),
      .o_chirp_k(i_chirp_k), .o_squelch(i_squelch));

   always #2 i_core_clk = ~i_core_clk;

   function automatic logic [1:0] exp_sens(input logic op, input logic pin);
      return op ? 2'h1 : (pin ? 2'h2 : 2'h0);
   endfunction
   function automatic logic [1:0] exp_boost(input logic op, input logic [1:0] s);
      return op ? BOOST_OPEN_LEVEL : s;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   task automatic chk(input logic [1:0] got, input logic [1:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("errors=%0d checks=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // r: boost open, sensitivity open, sensitivity level
   task automatic power_up(input logic [2:0] s, input logic [1:0] b,
      input logic [1:0] m);
      tick(1);
      i_reset <= 1'b1;
      i_reset_enable_n <= 1'b0;
      i_boost_strap_open <= s[2];
      i_sens_pin_open <= s[1];
      i_sens_pin_in <= s[0];
      i_boost_strap <= b;
      i_mgmt_clock_in <= m[1];
      i_mgmt_data_in <= m[0];
      tick(10);
      i_reset <= 1'b0;
      i_reset_enable_n <= 1'b1;
      tick(4);
      @(negedge i_core_clk);
   endtask
   task automatic flag_is(input logic v);
      tick(2);
      @(negedge i_core_clk);
      chk({1'b0, o_high_speed_active_flag}, {1'b0, v});
   endtask
   // Two-wire write of one byte; ak holds the drive seen at each ack clock
   task automatic mgmt_write(input logic [6:0] a, input logic [7:0] d,
      output logic [1:0] ak);
      logic [17:0] bits;
      bits = {a, 1'b0, 1'b1, d, 1'b1};
      ak = 2'h0;
      tick(1);
      i_mgmt_data_in <= 1'b0;
      tick(4);
      i_mgmt_clock_in <= 1'b0;
      for (int i = 17; i >= 0; i--)
      begin
         tick(4);
         i_mgmt_data_in <= bits[i];
         tick(4);
         i_mgmt_clock_in <= 1'b1;
         tick(3);
         @(negedge i_core_clk);
         if (i == 9)
            ak[1] = o_mgmt_data_oe;
         if (i == 0)
            ak[0] = o_mgmt_data_oe;
         tick(1);
         i_mgmt_clock_in <= 1'b0;
      end
      tick(4);
      i_mgmt_data_in <= 1'b0;
      tick(4);
      i_mgmt_clock_in <= 1'b1;
      tick(4);
      i_mgmt_data_in <= 1'b1;
      tick(4);
      @(negedge i_core_clk);
   endtask

   initial
   begin
      tick(20000);
      n_errors++;
      complete_run();
   end
   initial
   begin
      {i_core_clk, i_charge_port_enable_n, i_boost_strap} = 4'h0;
      {i_boost_strap_open, i_sens_pin_in, i_sens_pin_open} = 3'h0;
      {i_mgmt_clock_in, i_mgmt_data_in, i_line_disconnected} = 3'h0;
      {i_fixture_detect, i_test_packet} = 2'h0;
      i_reset = 1'b1;
      i_reset_enable_n = 1'b0;
      n_errors = 0;
      checked = 0;
      void'($urandom(32'hA02C));
      for (int k = 0; k < 6; k++)
      begin
         r = (k == 0) ? 3'h6 : ((k == 1) ? 3'h0 : 3'($urandom));
         st = 2'($urandom);
         power_up(r, st, 2'($urandom_range(0, 2)));
         chk(o_edge_boost, exp_boost(r[2], st));
         chk(o_dc_boost, exp_boost(r[2], st));
         chk(o_rx_sensitivity, exp_sens(r[1], r[0]));
         chk({1'b0, o_sens_pin_oe}, 2'h1);
         tick(1);
         i_boost_strap <= ~st;
         i_boost_strap_open <= ~r[2];
         i_charge_port_enable_n <= r[0];
         flag_is(1'b0);
         chk(o_edge_boost, exp_boost(r[2], st));
         chk({1'b0, o_charge_port_en}, {1'b0, ~r[0]});
      end
      urd_usb_partner_inst.send(CMIN, CMAX);
      flag_is(1'b1);
      chk({1'b0, o_sens_pin_out}, 2'h1);
      tick(1);
      i_reset_enable_n <= 1'b0;
      i_sens_pin_open <= 1'b1;
      flag_is(1'b0);
      chk({1'b0, o_active}, 2'h0);
      chk(o_rx_sensitivity, 2'h1);
      tick(1);
      i_reset_enable_n <= 1'b1;
      flag_is(1'b0);
      chk({1'b0, o_active}, 2'h1);
      urd_usb_partner_inst.send(CMIN - 1, CMAX);
      flag_is(1'b0);
      urd_usb_partner_inst.send(CMIN, CMAX + 1);
      flag_is(1'b0);
      tick(1);
      i_line_disconnected <= 1'b1;
      i_fixture_detect <= 1'b1;
      tick(1);
      {i_line_disconnected, i_fixture_detect} <= 2'h0;
      i_test_packet <= 1'b1;
      tick(1);
      i_test_packet <= 1'b0;
      flag_is(1'b1);
      power_up(3'h0, 2'h1, 2'h3);
      chk({1'b0, o_mgmt_mode}, 2'h1);
      chk({1'b0, o_sens_pin_oe}, 2'h0);
      chk(o_edge_boost, 2'h3);
      mgmt_write(MGMT_ADDR + 7'h1, MW, ack);
      chk(ack, 2'h0);
      chk(o_dc_boost, 2'h3);
      mgmt_write(MGMT_ADDR, MW, ack);
      chk(ack, 2'h3);
      chk(o_edge_boost, MW[BOOST_EDGE_LSB +: 2]);
      chk(o_dc_boost, MW[BOOST_DC_LSB +: 2]);
      chk({1'b0, o_mgmt_data_out}, 2'h0);
      complete_run();
   end
endmodule
`default_nettype wire

// ---- testbench/urd_usb_partner.sv ----
// Line-state model of the far USB host or device
`timescale 1ns/1ps
`default_nettype none
module urd_usb_partner
(
   input wire logic i_clk,
   output logic o_bus_reset,
   output logic o_chirp_j,
   output logic o_chirp_k,
   output logic o_squelch
);
   initial
   begin
      o_bus_reset = 1'b0;
      o_chirp_j = 1'b0;
      o_chirp_k = 1'b0;
      o_squelch = 1'b0;
   end
   // Bus reset, one J then K chirp of given lengths, then squelch
   task automatic send(input int nj, input int nk);
      @(posedge i_clk);
      o_bus_reset <= 1'b1;
      @(posedge i_clk);
      o_bus_reset <= 1'b0;
      o_chirp_j <= 1'b1;
      repeat (nj) @(posedge i_clk);
      o_chirp_j <= 1'b0;
      o_chirp_k <= 1'b1;
      repeat (nk) @(posedge i_clk);
      o_chirp_k <= 1'b0;
      @(posedge i_clk);
      o_squelch <= 1'b1;
      @(posedge i_clk);
      o_squelch <= 1'b0;
   endtask
endmodule
`default_nettype wire
